// *** design/sdm_pkg.sv ***
// Constants and types for the sectored data memory addressing block
package sdm_pkg;

    // ----------------------------------------------------------------
    // Special-function offsets in sector 0
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_PORT_SECTOR0 = 8'h00;
    localparam logic [7:0] OFS_POINTER_SECTOR0 = 8'h01;
    localparam logic [7:0] OFS_PORT_A = 8'h02;
    localparam logic [7:0] OFS_POINTER_A_LOW = 8'h03;
    localparam logic [7:0] OFS_POINTER_A_SECTOR = 8'h04;
    localparam logic [7:0] OFS_PORT_B = 8'h05;
    localparam logic [7:0] OFS_POINTER_B_LOW = 8'h06;
    localparam logic [7:0] OFS_POINTER_B_SECTOR = 8'h07;
    localparam logic [7:0] OFS_PROGRAM_BANK = 8'h08;

    // ----------------------------------------------------------------
    // Address layout
    // ----------------------------------------------------------------
    localparam int GP_AREA_BIT = 7;
    localparam int OFFSET_W = 8;
    localparam int BANK_W = 3;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_POINTER = 8'h00;
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [2:0] RST_BANK = 3'h0;

    // ----------------------------------------------------------------
    // APB register map, byte addresses
    // ----------------------------------------------------------------
    localparam int APB_ADDR_W = 12;
    localparam logic [11:0] APB_ACC = 12'h000;
    localparam logic [11:0] APB_PROGRAM_BANK = 12'h004;
    localparam logic [11:0] APB_LAST_BRANCH = 12'h008;
    localparam logic [11:0] APB_STATUS = 12'h00C;
    localparam logic [11:0] APB_POINTERS = 12'h010;

    // ----------------------------------------------------------------
    // Enumerations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_LOAD,
        OP_STORE,
        OP_ALU_ACC,
        OP_ALU_MEM
    } sdm_op_t;

    typedef enum logic [3:0] {
        FN_ADD,
        FN_SUB,
        FN_AND,
        FN_OR,
        FN_XOR,
        FN_INC,
        FN_DEC,
        FN_CLR,
        FN_SHL,
        FN_SHR,
        FN_PASS
    } sdm_fn_t;

    typedef enum logic [1:0] {
        KIND_ZERO,
        KIND_SFR,
        KIND_RAM
    } sdm_kind_t;

endpackage : sdm_pkg

// *** design/sdm_ram.sv ***
// General purpose data memory with registered read data
`timescale 1ns/100ps
module sdm_ram #(
    parameter int ADDR_W = 9,
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data
);

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // ----------------------------------------------------------------
    // Write port
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end

endmodule : sdm_ram

// *** design/sdm_alu.sv ***
// Arithmetic, logic and rotate unit feeding the accumulator
`timescale 1ns/100ps
module sdm_alu (
    input wire logic [7:0] acc,
    input wire logic [7:0] mem,
    input wire logic [3:0] fn,
    output logic [7:0] result
);

    // ----------------------------------------------------------------
    // Operation select
    // ----------------------------------------------------------------
    always_comb begin
        case (sdm_pkg::sdm_fn_t'(fn))
            sdm_pkg::FN_ADD: result = acc + mem;
            sdm_pkg::FN_SUB: result = acc - mem;
            sdm_pkg::FN_AND: result = acc & mem;
            sdm_pkg::FN_OR: result = acc | mem;
            sdm_pkg::FN_XOR: result = acc ^ mem;
            sdm_pkg::FN_INC: result = mem + 8'h01;
            sdm_pkg::FN_DEC: result = mem - 8'h01;
            sdm_pkg::FN_CLR: result = 8'h00;
            sdm_pkg::FN_SHL: result = {mem[6:0], mem[7]};
            sdm_pkg::FN_SHR: result = {mem[0], mem[7:1]};
            sdm_pkg::FN_PASS: result = mem;
            default: result = mem;
        endcase
    end

endmodule : sdm_alu

// *** design/sdm_addressing.sv ***
// Sectored data memory addressing unit with APB register access
`timescale 1ns/100ps
module sdm_addressing #(
    parameter int SECTOR_W = 2,
    parameter int BRANCH_W = 13
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic core_valid,
    input wire logic [1:0] core_op,
    input wire logic [3:0] core_fn,
    input wire logic core_ext,
    input wire logic [SECTOR_W+7:0] core_addr,
    output logic core_busy,
    output logic core_done,
    output logic [7:0] core_rdata,
    output logic [7:0] core_acc,
    output logic [SECTOR_W+7:0] core_target,
    input wire logic core_branch,
    input wire logic [BRANCH_W-1:0] core_branch_target,
    output logic branch_valid,
    output logic [BRANCH_W+2:0] branch_addr
);

    localparam int ADDR_W = SECTOR_W + 8;
    localparam int RAM_W = SECTOR_W + 7;

    typedef enum {
        ST_IDLE,
        ST_EXEC
    } sdm_state_t;

    sdm_state_t state;
    logic [7:0] pointer_sector0;
    logic [7:0] pointer_a_low;
    logic [7:0] pointer_a_sector;
    logic [7:0] pointer_b_low;
    logic [7:0] pointer_b_sector;
    logic [2:0] bank_select_bits;
    logic [ADDR_W-1:0] full_addr;
    logic [ADDR_W-1:0] next_target;
    logic [7:0] sel_sector;
    logic out_of_range;
    sdm_pkg::sdm_kind_t next_kind;
    logic [7:0] sfr_read;
    sdm_pkg::sdm_kind_t kind;
    sdm_pkg::sdm_op_t op;
    logic [3:0] fn;
    logic [7:0] sfr_data;
    logic [7:0] ram_rdata;
    logic [7:0] mem_value;
    logic [7:0] alu_result;
    logic [7:0] store_value;
    logic mem_write;
    logic sfr_write;
    logic ram_write;
    logic accept;
    logic apb_write;
    logic [7:0] tgt_offset;

    assign accept = core_valid && !core_busy;
    assign apb_write = psel && penable && pready && pwrite;

    // ----------------------------------------------------------------
    // Address resolution
    // ----------------------------------------------------------------
    always_comb begin
        full_addr = core_ext ? core_addr
            : {{SECTOR_W{1'b0}}, core_addr[7:0]};
        next_target = full_addr;
        sel_sector = 8'h00;
        out_of_range = 1'b0;
        if (full_addr[ADDR_W-1:8] == '0) begin
            case (full_addr[7:0])
                sdm_pkg::OFS_PORT_SECTOR0: begin
                    next_target = {{SECTOR_W{1'b0}}, pointer_sector0};
                end
                sdm_pkg::OFS_PORT_A: begin
                    sel_sector = pointer_a_sector;
                    next_target = {pointer_a_sector[SECTOR_W-1:0],
                        pointer_a_low};
                end
                sdm_pkg::OFS_PORT_B: begin
                    sel_sector = pointer_b_sector;
                    next_target = {pointer_b_sector[SECTOR_W-1:0],
                        pointer_b_low};
                end
                default: begin
                    next_target = full_addr;
                end
            endcase
        end
        out_of_range = (sel_sector >> SECTOR_W) != 8'h00;
    end

    assign tgt_offset = next_target[7:0];

    // ----------------------------------------------------------------
    // Target classification and special-function read
    // ----------------------------------------------------------------
    always_comb begin
        next_kind = sdm_pkg::KIND_ZERO;
        sfr_read = sdm_pkg::READ_ZERO;
        if (out_of_range) begin
            next_kind = sdm_pkg::KIND_ZERO;
        end else if (tgt_offset[sdm_pkg::GP_AREA_BIT]) begin
            next_kind = sdm_pkg::KIND_RAM;
        end else if (next_target[ADDR_W-1:8] == '0) begin
            next_kind = sdm_pkg::KIND_SFR;
            case (tgt_offset)
                sdm_pkg::OFS_POINTER_SECTOR0: sfr_read = pointer_sector0;
                sdm_pkg::OFS_POINTER_A_LOW: sfr_read = pointer_a_low;
                sdm_pkg::OFS_POINTER_A_SECTOR: sfr_read = pointer_a_sector;
                sdm_pkg::OFS_POINTER_B_LOW: sfr_read = pointer_b_low;
                sdm_pkg::OFS_POINTER_B_SECTOR: sfr_read = pointer_b_sector;
                sdm_pkg::OFS_PROGRAM_BANK: begin
                    sfr_read = {5'h00, bank_select_bits};
                end
                default: begin
                    next_kind = sdm_pkg::KIND_ZERO;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Request sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            core_busy <= 1'b0;
            core_done <= 1'b0;
        end else begin
            core_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        state <= ST_EXEC;
                        core_busy <= 1'b1;
                    end
                end
                ST_EXEC: begin
                    state <= ST_IDLE;
                    core_busy <= 1'b0;
                    core_done <= 1'b1;
                end
                default: begin
                    state <= ST_IDLE;
                    core_busy <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Captured request
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kind <= sdm_pkg::KIND_ZERO;
            op <= sdm_pkg::OP_LOAD;
            fn <= 4'h0;
            sfr_data <= 8'h00;
            core_target <= '0;
        end else if (accept) begin
            kind <= next_kind;
            op <= sdm_pkg::sdm_op_t'(core_op);
            fn <= core_fn;
            sfr_data <= sfr_read;
            core_target <= next_target;
        end
    end

    // ----------------------------------------------------------------
    // Data path
    // ----------------------------------------------------------------
    sdm_ram #(
        .ADDR_W(RAM_W),
        .DATA_W(8)
    ) u_ram (
        .clk(pclk),
        .rd_addr({next_target[ADDR_W-1:8], tgt_offset[6:0]}),
        .rd_data(ram_rdata),
        .wr_en(ram_write),
        .wr_addr({core_target[ADDR_W-1:8], core_target[6:0]}),
        .wr_data(store_value)
    );

    sdm_alu u_alu (
        .acc(core_acc),
        .mem(mem_value),
        .fn(fn),
        .result(alu_result)
    );

    always_comb begin
        case (kind)
            sdm_pkg::KIND_RAM: mem_value = ram_rdata;
            sdm_pkg::KIND_SFR: mem_value = sfr_data;
            default: mem_value = sdm_pkg::READ_ZERO;
        endcase
    end

    // Only load, store and the two ALU forms exist
    always_comb begin
        case (op)
            sdm_pkg::OP_STORE: begin
                store_value = core_acc;
                mem_write = 1'b1;
            end
            sdm_pkg::OP_ALU_MEM: begin
                store_value = alu_result;
                mem_write = 1'b1;
            end
            default: begin
                store_value = core_acc;
                mem_write = 1'b0;
            end
        endcase
    end

    assign ram_write = (state == ST_EXEC) && mem_write
        && (kind == sdm_pkg::KIND_RAM);
    assign sfr_write = (state == ST_EXEC) && mem_write
        && (kind == sdm_pkg::KIND_SFR);

    // ----------------------------------------------------------------
    // Accumulator and read data
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_acc <= sdm_pkg::RST_ACC;
            core_rdata <= 8'h00;
        end else if (state == ST_EXEC) begin
            core_rdata <= mem_value;
            case (op)
                sdm_pkg::OP_LOAD: core_acc <= mem_value;
                sdm_pkg::OP_ALU_ACC: core_acc <= alu_result;
                sdm_pkg::OP_ALU_MEM: core_acc <= alu_result;
                default: core_acc <= core_acc;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pointer registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pointer_sector0 <= sdm_pkg::RST_POINTER;
            pointer_a_low <= sdm_pkg::RST_POINTER;
            pointer_a_sector <= sdm_pkg::RST_POINTER;
            pointer_b_low <= sdm_pkg::RST_POINTER;
            pointer_b_sector <= sdm_pkg::RST_POINTER;
        end else if (sfr_write) begin
            // Each byte updates alone, so low bytes wrap in eight bits
            case (core_target[7:0])
                sdm_pkg::OFS_POINTER_SECTOR0: begin
                    pointer_sector0 <= store_value;
                end
                sdm_pkg::OFS_POINTER_A_LOW: begin
                    pointer_a_low <= store_value;
                end
                sdm_pkg::OFS_POINTER_A_SECTOR: begin
                    pointer_a_sector <= store_value;
                end
                sdm_pkg::OFS_POINTER_B_LOW: begin
                    pointer_b_low <= store_value;
                end
                sdm_pkg::OFS_POINTER_B_SECTOR: begin
                    pointer_b_sector <= store_value;
                end
                default: begin
                    pointer_sector0 <= pointer_sector0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Program bank select
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_select_bits <= sdm_pkg::RST_BANK;
        end else if (sfr_write
            && core_target[7:0] == sdm_pkg::OFS_PROGRAM_BANK) begin
            bank_select_bits <= store_value[2:0];
        end else if (apb_write && paddr == sdm_pkg::APB_PROGRAM_BANK) begin
            bank_select_bits <= pwdata[2:0];
        end
    end

    // ----------------------------------------------------------------
    // Branch target
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            branch_valid <= 1'b0;
            branch_addr <= '0;
        end else begin
            branch_valid <= core_branch;
            if (core_branch) begin
                // Codes 11x pass through unchanged and are undefined
                branch_addr <= {bank_select_bits, core_branch_target};
            end
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable) begin
                case (paddr)
                    sdm_pkg::APB_ACC: begin
                        prdata <= {24'h000000, core_acc};
                    end
                    sdm_pkg::APB_PROGRAM_BANK: begin
                        prdata <= {29'h0, bank_select_bits};
                    end
                    sdm_pkg::APB_LAST_BRANCH: begin
                        prdata <= 32'(branch_addr);
                    end
                    sdm_pkg::APB_STATUS: begin
                        prdata <= {15'h0, core_busy, 16'(core_target)};
                    end
                    sdm_pkg::APB_POINTERS: begin
                        prdata <= {pointer_b_low, pointer_a_sector,
                            pointer_a_low, pointer_sector0};
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule : sdm_addressing

// *** verification/sdm_addressing_monitor.sv ***
// Checker for the sectored data memory addressing unit
`timescale 1ns/100ps
module sdm_addressing_monitor #(
    parameter int SECTOR_W = 2,
    parameter int BRANCH_W = 13
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic core_valid,
    input wire logic [1:0] core_op,
    input wire logic [3:0] core_fn,
    input wire logic core_ext,
    input wire logic [SECTOR_W+7:0] core_addr,
    input wire logic core_busy,
    input wire logic core_done,
    input wire logic [7:0] core_rdata,
    input wire logic [7:0] core_acc,
    input wire logic [SECTOR_W+7:0] core_target,
    input wire logic core_branch,
    input wire logic [BRANCH_W-1:0] core_branch_target,
    input wire logic branch_valid,
    input wire logic [BRANCH_W+2:0] branch_addr
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire take = core_valid && !core_busy;

    chk_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    chk_err_data: assert property (pslverr |-> pready && prdata == 0)
        else $error("error response carries data");
    chk_bank_upper: assert property (
        pready && !pwrite && paddr == sdm_pkg::APB_PROGRAM_BANK
        |-> prdata[31:3] == 0) else $error("bank upper bits set");
    chk_take_done: assert property (take |=> core_busy ##1
        (core_done && !core_busy)) else $error("bad request timing");
    chk_port0_sector: assert property (
        take && !core_ext && core_addr[7:0] == sdm_pkg::OFS_PORT_SECTOR0
        |-> ##2 core_target[SECTOR_W+7:8] == 0)
        else $error("sector 0 port left sector 0");
    chk_ext_direct: assert property (
        take && core_ext && core_addr[7]
        |-> ##2 core_target == $past(core_addr, 2))
        else $error("extended address resolved wrongly");
    chk_unused_zero: assert property (
        take && core_op == sdm_pkg::OP_LOAD && !core_ext
        && core_addr[7:0] inside {[8'h09:8'h7F]}
        |-> ##2 core_rdata == 0 && core_acc == 0)
        else $error("unused location read nonzero");
    chk_alu_acc: assert property (
        take && core_op == sdm_pkg::OP_ALU_MEM && core_fn == sdm_pkg::FN_CLR
        |-> ##2 core_acc == 0) else $error("result missed accumulator");
    chk_branch_target: assert property (core_branch |=>
        branch_valid && branch_addr[BRANCH_W-1:0] == $past(core_branch_target))
        else $error("branch target wrong");
endmodule : sdm_addressing_monitor

bind sdm_addressing sdm_addressing_monitor #(
    .SECTOR_W(SECTOR_W), .BRANCH_W(BRANCH_W)) u_mon (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .core_valid, .core_op, .core_fn, .core_ext, .core_addr, .core_busy,
    .core_done, .core_rdata, .core_acc, .core_target, .core_branch,
    .core_branch_target, .branch_valid, .branch_addr);

// *** verification/sdm_core_model.sv ***
// Instruction execution side that issues core and branch requests
`timescale 1ns/100ps
module sdm_core_model (
    input wire logic pclk,
    input wire logic core_busy,
    input wire logic core_done,
    input wire logic branch_valid,
    input wire logic [15:0] branch_addr,
    output logic core_valid,
    output logic [1:0] core_op,
    output logic [3:0] core_fn,
    output logic core_ext,
    output logic [9:0] core_addr,
    output logic core_branch,
    output logic [12:0] core_branch_target
);
    // ----------------------------------------------------------------
    // Requests
    // ----------------------------------------------------------------
    initial begin
        core_valid = 1'b0;
        core_op = 2'h0;
        core_fn = 4'h0;
        core_ext = 1'b0;
        core_addr = 10'h000;
        core_branch = 1'b0;
        core_branch_target = 13'h0000;
    end

    // Data moves only through the accumulator
    task automatic run(input logic [1:0] o, input logic [3:0] f,
        input logic [9:0] a);
        @(posedge pclk);
        core_valid <= 1'b1;
        core_op <= o;
        core_fn <= f;
        core_ext <= |a[9:8];
        core_addr <= a;
        do @(posedge pclk); while (core_busy !== 1'b0);
        core_valid <= 1'b0;
        core_addr <= ~a;
        do @(posedge pclk); while (core_done !== 1'b1);
    endtask : run

    // Bank is loaded by the caller before the branch
    task automatic branch(input logic [12:0] t, output logic v,
        output logic [15:0] got);
        @(posedge pclk);
        core_branch <= 1'b1;
        core_branch_target <= t;
        @(posedge pclk);
        core_branch <= 1'b0;
        core_branch_target <= ~t;
        @(posedge pclk);
        v = branch_valid;
        got = branch_addr;
    endtask : branch
endmodule : sdm_core_model

// *** verification/sdm_addressing_tb.sv ***
// Testbench for the sectored data memory addressing unit
`timescale 1ns/100ps
module sdm_addressing_tb;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    localparam logic [1:0] LD = 2'(sdm_pkg::OP_LOAD);
    localparam logic [1:0] AM = 2'(sdm_pkg::OP_ALU_MEM);
    localparam logic [3:0] CLR = 4'(sdm_pkg::FN_CLR);
    localparam logic [3:0] INC = 4'(sdm_pkg::FN_INC);
    localparam logic [3:0] DEC = 4'(sdm_pkg::FN_DEC);
    localparam logic [3:0] PAS = 4'(sdm_pkg::FN_PASS);
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, v, core_valid, core_ext, core_busy;
    logic core_done, core_branch, branch_valid;
    logic [1:0] core_op;
    logic [3:0] core_fn;
    logic [9:0] core_addr, core_target;
    logic [7:0] core_rdata, core_acc;
    logic [12:0] core_branch_target;
    logic [15:0] branch_addr, ba;
    int n_errors = 0;
    int checked = 0;

    initial begin
        forever #25 pclk = ~pclk;
    end

    sdm_addressing dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .core_valid, .core_op,
        .core_fn, .core_ext, .core_addr, .core_busy, .core_done,
        .core_rdata, .core_acc, .core_target, .core_branch,
        .core_branch_target, .branch_valid, .branch_addr);
    sdm_core_model core (.pclk, .core_busy, .core_done, .branch_valid,
        .branch_addr, .core_valid, .core_op, .core_fn, .core_ext,
        .core_addr, .core_branch, .core_branch_target);

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : compare

    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        compare(32'(pready), 32'h1);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic op(input logic [1:0] o, input logic [3:0] f,
        input logic [9:0] a);
        core.run(o, f, a);
    endtask : op

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        apb(1'b0, sdm_pkg::APB_PROGRAM_BANK, 32'h0);
        compare(rd, 32'h0);
        apb(1'b1, sdm_pkg::APB_PROGRAM_BANK, 32'hFFFFFFFF);
        apb(1'b0, sdm_pkg::APB_PROGRAM_BANK, 32'h0);
        compare(rd, 32'h7);
        apb(1'b1, sdm_pkg::APB_ACC, 32'hFF);
        apb(1'b0, sdm_pkg::APB_ACC, 32'h0);
        compare(rd, 32'h0);
        apb(1'b0, 12'hFF0, 32'h0);
        compare({31'h0, err}, 32'h1);
        compare(rd, 32'h0);
    endtask : t_regs

    task automatic t_branch;
        for (int c = 0; c < 6; c++) begin
            apb(1'b1, sdm_pkg::APB_PROGRAM_BANK, 32'(c));
            core.branch(13'h1A5B ^ 13'(c), v, ba);
            compare({15'h0, v, ba}, {15'h0, 1'b1, 3'(c), 13'h1A5B ^ 13'(c)});
        end
    endtask : t_branch

    task automatic t_direct;
        op(AM, CLR, 10'h0F0);
        op(AM, CLR, 10'h1F0);
        op(AM, DEC, 10'h1F0);
        compare(32'(core_acc), 32'hFF);
        op(LD, PAS, 10'h0F0);
        compare(32'(core_acc), 32'h0);
        op(LD, PAS, 10'h1F0);
        compare(32'({core_target, core_acc}), 32'h1F0FF);
        op(2'h1, PAS, 10'h0F0);
        op(2'h2, 4'h0, 10'h0F0);
        compare(32'(core_acc), 32'hFE);
    endtask : t_direct

    task automatic t_indirect;
        op(AM, CLR, 10'h1FF);
        op(AM, CLR, 10'h003);
        op(AM, DEC, 10'h003);
        op(AM, CLR, 10'h004);
        op(AM, INC, 10'h004);
        op(AM, INC, 10'h002);
        compare(32'({core_target, core_acc}), 32'h1FF01);
        op(LD, PAS, 10'h1FF);
        compare(32'(core_acc), 32'h01);
        op(AM, INC, 10'h003);
        apb(1'b0, sdm_pkg::APB_POINTERS, 32'h0);
        compare(32'(rd[23:8]), 32'h0100);
    endtask : t_indirect

    task automatic t_port0;
        op(AM, CLR, 10'h001);
        op(AM, DEC, 10'h001);
        op(LD, PAS, 10'h000);
        compare(32'(core_target), 32'h0FF);
        op(AM, CLR, 10'h001);
        op(AM, INC, 10'h001);
        op(AM, INC, 10'h001);
        op(LD, PAS, 10'h000);
        compare(32'(core_rdata), 32'h0);
    endtask : t_port0

    task automatic t_unused;
        op(AM, CLR, 10'h0F1);
        op(AM, DEC, 10'h0F1);
        op(LD, PAS, 10'h010);
        compare(32'({core_rdata, core_acc}), 32'h0);
        op(AM, DEC, 10'h0F1);
        op(LD, PAS, 10'h37E);
        compare(32'({core_rdata, core_acc}), 32'h0);
    endtask : t_unused

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_branch();
        t_direct();
        t_indirect();
        t_port0();
        t_unused();
        tally_and_finish();
    end

    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
endmodule : sdm_addressing_tb
